/* File: src/ific_defs.svh */
// Purpose: Offsets, field positions, reset values and vector figures of the
//          interrupt flag and enable register set.
// Assumes: Included by its bare name from every file that needs it.
// Notes:   Definitions only.
`ifndef IFIC_DEFS_SVH
`define IFIC_DEFS_SVH

// ==========================================================================
// Register addresses in the special-purpose data memory window.
`define IFIC_ADDR_EDGE 8'h00
`define IFIC_ADDR_C0 8'h01
`define IFIC_ADDR_C1 8'h02
`define IFIC_ADDR_C2 8'h03
`define IFIC_ADDR_C3 8'h04

// ==========================================================================
// Reset values of every register.
`define IFIC_RST_EDGE 8'h00
`define IFIC_RST_C0 8'h00
`define IFIC_RST_C1 8'h00
`define IFIC_RST_C2 8'h00
`define IFIC_RST_C3 8'h00

// ==========================================================================
// Field positions.
`define IFIC_EDGE_LO_BIT 0
`define IFIC_EDGE_HI_BIT 1
`define IFIC_C0_GLOBAL_EN_BIT 0
`define IFIC_C0_EXT_EN_BIT 1
`define IFIC_C0_TOUCH_EN_BIT 2
`define IFIC_C0_TB0_EN_BIT 3
`define IFIC_C0_EXT_FLAG_BIT 4
`define IFIC_C0_TOUCH_FLAG_BIT 5
`define IFIC_C0_TB0_FLAG_BIT 6
`define IFIC_C1_CTMP_EN_BIT 0
`define IFIC_C1_CTMA_EN_BIT 1
`define IFIC_C1_PTMP_EN_BIT 2
`define IFIC_C1_PTMA_EN_BIT 3
`define IFIC_C1_CTMP_FLAG_BIT 4
`define IFIC_C1_CTMA_FLAG_BIT 5
`define IFIC_C1_PTMP_FLAG_BIT 6
`define IFIC_C1_PTMA_FLAG_BIT 7
`define IFIC_C2_TB1_EN_BIT 0
`define IFIC_C2_IIC_EN_BIT 1
`define IFIC_C2_EE_EN_BIT 2
`define IFIC_C2_UART_EN_BIT 3
`define IFIC_C2_TB1_FLAG_BIT 4
`define IFIC_C2_IIC_FLAG_BIT 5
`define IFIC_C2_EE_FLAG_BIT 6
`define IFIC_C2_UART_FLAG_BIT 7
`define IFIC_C3_LVD_EN_BIT 0
`define IFIC_C3_LVD_FLAG_BIT 4

// ==========================================================================
// Vector addresses: first vector and spacing between sources.
`define IFIC_VEC_BASE 8'h04
`define IFIC_VEC_STEP 8'h04

`endif

/* File: src/ific_edge_detect.sv */
// Purpose: Synchronises the external interrupt pin and detects chosen edges.
// Assumes: The pin is asynchronous to the system clock.
// Notes:   The first synchroniser stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none

module ific_edge_detect
  import ific_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ext_pin,
  ific_edge_if.det edge_bus
);

  logic sync1_reg;
  logic sync1_next;
  logic sync2_reg;
  logic sync2_next;
  logic prev_reg;
  logic prev_next;
  logic rise;
  logic fall;

  // ========================================================================
  // Synchroniser and previous-level register.
  always_comb begin
    sync1_next = i_ext_pin;
    sync2_next = sync1_reg;
    prev_next = sync2_reg;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      prev_reg <= prev_next;
    end
  end

  // Edge decode per the two-bit mode; zero mode yields no event.
  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;
  always_comb begin
    case (edge_bus.mode)
      IFIC_EDGE_RISE: edge_bus.pin_evt = rise;
      IFIC_EDGE_FALL: edge_bus.pin_evt = fall;
      IFIC_EDGE_BOTH: edge_bus.pin_evt = rise | fall;
      default: edge_bus.pin_evt = 1'b0;
    endcase
  end

  // ========================================================================
  // Checks on edge decoding.
  edge_off_quiet_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (edge_bus.mode == IFIC_EDGE_OFF) |-> !edge_bus.pin_evt)
    else $error("Pin event while edge detection is off.");
  rise_seen_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (edge_bus.mode == IFIC_EDGE_RISE) && $rose(sync2_reg) |-> edge_bus.pin_evt)
    else $error("Rising edge missed in rising mode.");
  fall_only_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (edge_bus.mode == IFIC_EDGE_FALL) && edge_bus.pin_evt |-> $fell(sync2_reg))
    else $error("Falling mode event without a falling edge.");
  dual_cov: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (edge_bus.mode == IFIC_EDGE_BOTH) && edge_bus.pin_evt);

endmodule : ific_edge_detect

`default_nettype wire

/* File: src/ific_edge_if.sv */
// Purpose: Carries the edge mode to the pin detector and its event back.
// Assumes: Both ends run on the system clock.
// Notes:   The event is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Edge mode and pin event bundle.
interface ific_edge_if;
  import ific_pkg::*;
  ific_edge_mode_type mode;
  logic pin_evt;
  modport ctrl (output mode, input pin_evt);
  modport det (input mode, output pin_evt);
endinterface : ific_edge_if

`default_nettype wire

/* File: src/ific_pkg.sv */
// Purpose: Types shared by the interrupt flag and enable register set.
// Assumes: Nothing beyond the defines header.
// Notes:   Source indices follow vector priority, index 0 highest.
`default_nettype none

package ific_pkg;

  // ========================================================================
  // Edge selection of the external pin, in field encoding order.
  typedef enum logic [1:0] {
    IFIC_EDGE_OFF,
    IFIC_EDGE_RISE,
    IFIC_EDGE_FALL,
    IFIC_EDGE_BOTH
  } ific_edge_mode_type;

  // ========================================================================
  // Interrupt sources in priority order.
  typedef enum logic [3:0] {
    IFIC_SRC_EXT,
    IFIC_SRC_TOUCH,
    IFIC_SRC_TB0,
    IFIC_SRC_CTMP,
    IFIC_SRC_CTMA,
    IFIC_SRC_PTMP,
    IFIC_SRC_PTMA,
    IFIC_SRC_TB1,
    IFIC_SRC_IIC,
    IFIC_SRC_EE,
    IFIC_SRC_UART,
    IFIC_SRC_LVD
  } ific_src_type;

endpackage : ific_pkg

`default_nettype wire

/* File: src/ific_regs.sv */
// Purpose: Interrupt request flags, enables, global enable and pin edge select.
// Assumes: Core accesses registers as data memory on the system clock.
// Notes:   Peripheral events are same-clock one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
`include "ific_defs.svh"

module ific_regs
  import ific_pkg::*;
#(
  parameter int NSRC = 12
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ext_pin,
  input wire logic [NSRC-2:0] i_periph_evt,
  input wire logic [7:0] i_addr,
  input wire logic i_wr_en,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_en,
  output logic [7:0] o_rd_data,
  input wire logic i_stack_full,
  input wire logic i_irq_accept,
  input wire logic i_reti,
  output logic o_irq_req,
  output logic o_irq_ack,
  output logic [7:0] o_irq_vector,
  output logic o_wake_req
);

  // ========================================================================
  // Per-source placement: register address, flag bit and enable bit.
  localparam logic [7:0] SRC_ADDR [NSRC] = '{
    `IFIC_ADDR_C0, `IFIC_ADDR_C0, `IFIC_ADDR_C0,
    `IFIC_ADDR_C1, `IFIC_ADDR_C1, `IFIC_ADDR_C1, `IFIC_ADDR_C1,
    `IFIC_ADDR_C2, `IFIC_ADDR_C2, `IFIC_ADDR_C2, `IFIC_ADDR_C2,
    `IFIC_ADDR_C3};
  localparam int FLAG_POS [NSRC] = '{
    `IFIC_C0_EXT_FLAG_BIT, `IFIC_C0_TOUCH_FLAG_BIT, `IFIC_C0_TB0_FLAG_BIT,
    `IFIC_C1_CTMP_FLAG_BIT, `IFIC_C1_CTMA_FLAG_BIT,
    `IFIC_C1_PTMP_FLAG_BIT, `IFIC_C1_PTMA_FLAG_BIT,
    `IFIC_C2_TB1_FLAG_BIT, `IFIC_C2_IIC_FLAG_BIT,
    `IFIC_C2_EE_FLAG_BIT, `IFIC_C2_UART_FLAG_BIT,
    `IFIC_C3_LVD_FLAG_BIT};
  localparam int EN_POS [NSRC] = '{
    `IFIC_C0_EXT_EN_BIT, `IFIC_C0_TOUCH_EN_BIT, `IFIC_C0_TB0_EN_BIT,
    `IFIC_C1_CTMP_EN_BIT, `IFIC_C1_CTMA_EN_BIT,
    `IFIC_C1_PTMP_EN_BIT, `IFIC_C1_PTMA_EN_BIT,
    `IFIC_C2_TB1_EN_BIT, `IFIC_C2_IIC_EN_BIT,
    `IFIC_C2_EE_EN_BIT, `IFIC_C2_UART_EN_BIT,
    `IFIC_C3_LVD_EN_BIT};

  // ========================================================================
  // Reset release and state declarations.
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n_sync;

  logic [NSRC-1:0] flag_reg;
  logic [NSRC-1:0] flag_next;
  logic [NSRC-1:0] en_reg;
  logic [NSRC-1:0] en_next;
  logic global_en_reg;
  logic global_en_next;
  ific_edge_mode_type edge_mode_reg;
  ific_edge_mode_type edge_mode_next;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic ack_reg;
  logic ack_next;
  logic [7:0] vector_reg;
  logic [7:0] vector_next;
  logic wake_reg;
  logic wake_next;

  logic [NSRC-1:0] evt;
  logic [NSRC-1:0] pend;
  logic [NSRC-1:0] take_onehot;
  logic [NSRC-1:0] wr_hit;
  logic [7:0] rd_part [NSRC];
  logic [3:0] win_idx;
  logic any_pend;
  logic irq_take;
  logic edge_wr;
  logic c0_wr;

  ific_edge_if edge_bus ();

  // Reset is released through two flops; assertion is still immediate.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n_sync = rst_sync_reg;

  // ========================================================================
  // External pin synchroniser and edge detector.
  ific_edge_detect u_edge (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(rst_n_sync),
    .i_ext_pin(i_ext_pin),
    .edge_bus(edge_bus)
  );
  assign edge_bus.mode = edge_mode_reg;

  // Pin event takes source slot 0; peripherals fill the rest in order.
  assign evt = {i_periph_evt, edge_bus.pin_evt};

  // ========================================================================
  // Per-source write decode and read contribution.
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_src
      assign wr_hit[gi] = i_wr_en && (i_addr == SRC_ADDR[gi]);
      always_comb begin
        rd_part[gi] = 8'h00;
        if (i_addr == SRC_ADDR[gi]) begin
          rd_part[gi][FLAG_POS[gi]] = flag_reg[gi];
          rd_part[gi][EN_POS[gi]] = en_reg[gi];
        end
      end
    end
  endgenerate

  assign edge_wr = i_wr_en && (i_addr == `IFIC_ADDR_EDGE);
  assign c0_wr = i_wr_en && (i_addr == `IFIC_ADDR_C0);

  // ========================================================================
  // Gating and priority: lowest index wins among enabled pending flags.
  assign pend = flag_reg & en_reg;
  assign any_pend = |pend;
  always_comb begin
    win_idx = 4'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        win_idx = 4'(i);
      end
    end
  end
  // Request needs global enable and room on the stack.
  assign o_irq_req = global_en_reg && any_pend && !i_stack_full;
  assign irq_take = o_irq_req && i_irq_accept;
  always_comb begin
    take_onehot = '0;
    if (irq_take) begin
      take_onehot[win_idx] = 1'b1;
    end
  end

  // ========================================================================
  // Next state of flags, enables, global enable and edge select.
  // A hardware event beats both a software clear and the service clear.
  always_comb begin
    flag_next = flag_reg;
    en_next = en_reg;
    for (int i = 0; i < NSRC; i++) begin
      if (wr_hit[i]) begin
        flag_next[i] = i_wr_data[FLAG_POS[i]];
        en_next[i] = i_wr_data[EN_POS[i]];
      end else if (take_onehot[i]) begin
        flag_next[i] = 1'b0;
      end
      if (evt[i]) begin
        flag_next[i] = 1'b1;
      end
    end
    // Service entry clears the global enable to prevent nesting.
    global_en_next = global_en_reg;
    if (irq_take) begin
      global_en_next = 1'b0;
    end else if (i_reti) begin
      global_en_next = 1'b1;
    end else if (c0_wr) begin
      global_en_next = i_wr_data[`IFIC_C0_GLOBAL_EN_BIT];
    end
    // Only bits 1 and 0 store; upper written bits are dropped.
    edge_mode_next = edge_mode_reg;
    if (edge_wr) begin
      edge_mode_next = ific_edge_mode_type'(
        {i_wr_data[`IFIC_EDGE_HI_BIT], i_wr_data[`IFIC_EDGE_LO_BIT]});
    end
  end

  // ========================================================================
  // Read data, acknowledge pulse, vector and wake request.
  always_comb begin
    rd_data_next = rd_data_reg;
    if (i_rd_en) begin
      rd_data_next = 8'h00;
      for (int i = 0; i < NSRC; i++) begin
        rd_data_next = rd_data_next | rd_part[i];
      end
      if (i_addr == `IFIC_ADDR_C0) begin
        rd_data_next[`IFIC_C0_GLOBAL_EN_BIT] = global_en_reg;
      end else if (i_addr == `IFIC_ADDR_EDGE) begin
        rd_data_next[`IFIC_EDGE_HI_BIT] = edge_mode_reg[1];
        rd_data_next[`IFIC_EDGE_LO_BIT] = edge_mode_reg[0];
      end
    end
    ack_next = irq_take;
    vector_next = vector_reg;
    if (irq_take) begin
      vector_next = 8'(`IFIC_VEC_BASE + `IFIC_VEC_STEP * {4'h0, win_idx});
    end
    wake_next = |flag_reg;
  end

  // Registers; reset leaves every interrupt off.
  always_ff @(posedge i_sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      flag_reg <= '0;
      en_reg <= '0;
      global_en_reg <= 1'b0;
      edge_mode_reg <= IFIC_EDGE_OFF;
      rd_data_reg <= 8'h00;
      ack_reg <= 1'b0;
      vector_reg <= 8'h00;
      wake_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
      en_reg <= en_next;
      global_en_reg <= global_en_next;
      edge_mode_reg <= edge_mode_next;
      rd_data_reg <= rd_data_next;
      ack_reg <= ack_next;
      vector_reg <= vector_next;
      wake_reg <= wake_next;
    end
  end

  assign o_rd_data = rd_data_reg;
  assign o_irq_ack = ack_reg;
  assign o_irq_vector = vector_reg;
  assign o_wake_req = wake_reg;

  // ========================================================================
  // Checks on register behaviour and interrupt gating.
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!rst_n_sync);

  edge_upper_zero_a: assert property (
    i_rd_en && (i_addr == `IFIC_ADDR_EDGE) |=> (o_rd_data[7:2] == 6'h00))
    else $error("Edge register upper bits read nonzero.");
  edge_write_keep_a: assert property (
    edge_wr |=> (edge_mode_reg == $past(i_wr_data[1:0])))
    else $error("Edge field did not take written value.");
  c0_top_zero_a: assert property (
    i_rd_en && (i_addr == `IFIC_ADDR_C0) |=> !o_rd_data[7])
    else $error("First control bit 7 read nonzero.");
  ext_flag_read_a: assert property (
    i_rd_en && (i_addr == `IFIC_ADDR_C0) && !i_wr_en
    |=> o_rd_data[`IFIC_C0_EXT_FLAG_BIT] == $past(flag_reg[IFIC_SRC_EXT]))
    else $error("Pin flag read from wrong bit.");
  ptma_flag_read_a: assert property (
    i_rd_en && (i_addr == `IFIC_ADDR_C1)
    |=> o_rd_data[`IFIC_C1_PTMA_FLAG_BIT] == $past(flag_reg[IFIC_SRC_PTMA]))
    else $error("Periodic comparator A flag misplaced.");
  event_sets_flag_a: assert property (
    (evt != '0) |=> ((flag_reg & $past(evt)) == $past(evt)))
    else $error("Source event did not set its flag.");
  req_needs_enable_a: assert property (
    o_irq_req |-> ((flag_reg & en_reg) != '0))
    else $error("Request raised without an enabled flag.");
  global_blocks_a: assert property (
    !global_en_reg |-> !o_irq_req)
    else $error("Request raised with global enable low.");
  take_clears_global_a: assert property (
    irq_take |=> !global_en_reg && o_irq_ack ##1 !o_irq_ack)
    else $error("Service entry did not clear global enable.");
  stack_full_hold_a: assert property (
    i_stack_full |-> !irq_take ##1 !o_irq_ack)
    else $error("Request acknowledged with full stack.");
  lvd_enable_read_a: assert property (
    i_rd_en && (i_addr == `IFIC_ADDR_C3)
    |=> o_rd_data[`IFIC_C3_LVD_EN_BIT] == $past(en_reg[IFIC_SRC_LVD]))
    else $error("Low-voltage enable misplaced.");

  take_cov: cover property (irq_take ##1 o_irq_ack);
  stack_wait_cov: cover property (i_stack_full && global_en_reg && any_pend ##1 irq_take);
  lvd_take_cov: cover property (irq_take && (win_idx == 4'(IFIC_SRC_LVD)));
  pin_take_cov: cover property (edge_bus.pin_evt ##[1:4] irq_take);

endmodule : ific_regs

`default_nettype wire

/* File: tb/ific_core_model.sv */
// Purpose: Core side of the interrupt handshake: takes requests, logs vectors.
// Assumes: Inputs are sampled and outputs move on the falling edge of the system clock.
// Notes:   The bench decides when the core is willing, so answers can be late.
`timescale 1ns/1ps
`default_nettype none

module ific_core_model (
  input wire logic i_sys_clk,
  input wire logic i_irq_ack,
  input wire logic [7:0] i_irq_vector,
  input wire logic i_take_en,
  output logic o_irq_accept,
  output logic [7:0] o_last_vector,
  output int o_ack_count
);
  // ==========================================================================
  // Start idle so no take can happen before the bench asks for one.
  logic accept_reg = 1'b0;
  logic [7:0] vector_reg = 8'h00;
  int count_reg = 0;

  // Willingness follows the bench; each acknowledge pulse is logged once.
  always @(negedge i_sys_clk) begin
    accept_reg <= i_take_en;
    if (i_irq_ack === 1'b1) begin
      vector_reg <= i_irq_vector;
      count_reg <= count_reg + 1;
    end
  end

  // One driver per output, each a plain copy of its register.
  assign o_irq_accept = accept_reg;
  assign o_last_vector = vector_reg;
  assign o_ack_count = count_reg;
endmodule : ific_core_model

`default_nettype wire

/* File: tb/tb_top.sv */
// Purpose: Register, event, edge and handshake checks of the interrupt registers.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Expected values come from the bit layout, never from the design.
`timescale 1ns/1ps
`default_nettype none
`include "ific_defs.svh"

module tb_top;
  import ific_pkg::*;
  logic i_sys_clk, i_rst_n, i_ext_pin, i_wr_en, i_rd_en, i_stack_full, i_reti;
  logic take_en, irq_accept, o_irq_req, o_irq_ack, o_wake_req;
  logic [10:0] i_periph_evt;
  logic [7:0] i_addr, i_wr_data, o_rd_data, o_irq_vector, last_vec;
  int errors, checks_done, ack_cnt;
  // Register and bit that each peripheral event sets.
  logic [7:0] evt_addr [11] = '{8'h01, 8'h01, 8'h02, 8'h02, 8'h02, 8'h02,
                                8'h03, 8'h03, 8'h03, 8'h03, 8'h04};
  int evt_bit [11] = '{5, 6, 4, 5, 6, 7, 4, 5, 6, 7, 4};
  // Readable mask of each address, the last one unmapped.
  logic [7:0] rd_mask [6] = '{8'h03, 8'h7f, 8'hff, 8'hff, 8'h11, 8'h00};

  ific_regs dut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ext_pin(i_ext_pin),
    .i_periph_evt(i_periph_evt), .i_addr(i_addr), .i_wr_en(i_wr_en),
    .i_wr_data(i_wr_data), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
    .i_stack_full(i_stack_full), .i_irq_accept(irq_accept), .i_reti(i_reti),
    .o_irq_req(o_irq_req), .o_irq_ack(o_irq_ack), .o_irq_vector(o_irq_vector),
    .o_wake_req(o_wake_req)
  );

  ific_core_model core (
    .i_sys_clk(i_sys_clk), .i_irq_ack(o_irq_ack), .i_irq_vector(o_irq_vector),
    .i_take_en(take_en), .o_irq_accept(irq_accept), .o_last_vector(last_vec),
    .o_ack_count(ack_cnt)
  );

  // ==========================================================================
  // Clock of 5 ns period.
  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end

  // ==========================================================================
  // Helpers.
  // Compares one byte and reports a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One write cycle.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    i_addr = a;
    i_wr_data = d;
    i_wr_en = 1'b1;
    @(negedge i_sys_clk);
    i_wr_en = 1'b0;
  endtask : wr

  // One read cycle, data checked once it is registered.
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge i_sys_clk);
    i_addr = a;
    i_rd_en = 1'b1;
    @(negedge i_sys_clk);
    i_rd_en = 1'b0;
    chk(o_rd_data, exp);
  endtask : rdchk

  // One-cycle peripheral event.
  task automatic pulse(input int i);
    @(negedge i_sys_clk);
    i_periph_evt[i] = 1'b1;
    @(negedge i_sys_clk);
    i_periph_evt = '0;
  endtask : pulse

  // Moves the pin and waits out the synchroniser.
  task automatic pin(input logic v);
    @(negedge i_sys_clk);
    i_ext_pin = v;
    repeat (8) @(negedge i_sys_clk);
  endtask : pin

  // Prints the verdict and ends the run.
  task automatic test_done;
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // ==========================================================================
  // Watchdog far beyond the few hundred cycles the tests need.
  initial begin
    #100000;
    errors++;
    test_done();
  end

  // ==========================================================================
  // Main sequence.
  initial begin
    {i_rst_n, i_ext_pin, i_wr_en, i_rd_en, i_stack_full, i_reti, take_en} = '0;
    i_periph_evt = '0;
    i_addr = 8'h00;
    i_wr_data = 8'h00;
    repeat (16) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    repeat (3) @(negedge i_sys_clk);
    // Reset values, then masks of all-ones writes, then software clears.
    for (int a = 0; a < 6; a++) begin
      rdchk(8'(a), 8'h00);
      wr(8'(a), 8'hff);
      rdchk(8'(a), rd_mask[a]);
      wr(8'(a), 8'h00);
      rdchk(8'(a), 8'h00);
    end
    // Every peripheral event lands on its own flag only.
    for (int i = 0; i < 11; i++) begin
      pulse(i);
      rdchk(evt_addr[i], 8'h01 << evt_bit[i]);
      wr(evt_addr[i], 8'h00);
    end
    // Each edge mode against a rising and then a falling pin.
    for (int m = 0; m < 4; m++) begin
      wr(`IFIC_ADDR_EDGE, 8'(m));
      pin(1'b1);
      rdchk(`IFIC_ADDR_C0, (m == 1 || m == 3) ? 8'h10 : 8'h00);
      wr(`IFIC_ADDR_C0, 8'h00);
      pin(1'b0);
      rdchk(`IFIC_ADDR_C0, (m >= 2) ? 8'h10 : 8'h00);
      wr(`IFIC_ADDR_C0, 8'h00);
    end
    wr(`IFIC_ADDR_EDGE, 8'h00);
    // Touch and time base 0 pending; gate by enable, global and stack.
    pulse(0);
    pulse(1);
    wr(`IFIC_ADDR_C0, 8'h61);
    chk({7'h00, o_irq_req}, 8'h00);
    wr(`IFIC_ADDR_C0, 8'h6c);
    chk({7'h00, o_irq_req}, 8'h00);
    chk({7'h00, o_wake_req}, 8'h01);
    i_stack_full = 1'b1;
    wr(`IFIC_ADDR_C0, 8'h6d);
    take_en = 1'b1;
    repeat (4) @(negedge i_sys_clk);
    chk({7'h00, o_irq_req}, 8'h00);
    chk(8'(ack_cnt), 8'h00);
    i_stack_full = 1'b0;
    repeat (4) @(negedge i_sys_clk);
    chk(8'(ack_cnt), 8'h01);
    chk(last_vec, 8'h08);
    rdchk(`IFIC_ADDR_C0, 8'h4c);
    pulse(0);
    rdchk(`IFIC_ADDR_C0, 8'h6c);
    chk(8'(ack_cnt), 8'h01);
    // Return from service re-enables; touch wins again, then time base 0.
    @(negedge i_sys_clk);
    i_reti = 1'b1;
    @(negedge i_sys_clk);
    i_reti = 1'b0;
    repeat (4) @(negedge i_sys_clk);
    chk(8'(ack_cnt), 8'h02);
    chk(last_vec, 8'h08);
    wr(`IFIC_ADDR_C0, 8'h4d);
    repeat (4) @(negedge i_sys_clk);
    chk(8'(ack_cnt), 8'h03);
    chk(last_vec, 8'h0c);
    take_en = 1'b0;
    rdchk(`IFIC_ADDR_C0, 8'h0c);
    // With every flag serviced, the wake request has dropped again.
    chk({7'h00, o_wake_req}, 8'h00);
    test_done();
  end
endmodule : tb_top

`default_nettype wire
